// ### hdl/cprs_regs.svh
/*
  Timing constants of the power-up and reset sequencer.
  Assumes a 50 MHz reference clock; counts follow from the millisecond delays.
*/
`ifndef CPRS_REGS_SVH
`define CPRS_REGS_SVH


`define CPRS_CLK_KHZ 50000
`define CPRS_LOCK_MS 100
`define CPRS_PG_IGN_MS 60
`define CPRS_LOCK_CYC (`CPRS_LOCK_MS * `CPRS_CLK_KHZ)
`define CPRS_PG_IGN_CYC (`CPRS_PG_IGN_MS * `CPRS_CLK_KHZ)

`endif

// ### hdl/cprs_pkg.sv
/*
  Types of the power-up and reset sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cprs_pkg;

  typedef enum logic [3:0] {
    ST_OFF     = 4'h0,
    ST_SYSRST  = 4'h1,
    ST_LOCK    = 4'h2,
    ST_BOOT    = 4'h3,
    ST_DCGRATE = 4'h4,
    ST_PLLEN   = 4'h5,
    ST_MCLK    = 4'h6,
    ST_DIVREL  = 4'h7,
    ST_MEMTEST = 4'h8,
    ST_DONE    = 4'h9,
    ST_STANDBY = 4'hA,
    ST_PARK    = 4'hB
  } cprs_state_t;

  typedef struct packed {
    logic master_pll_rstn;
    logic core_rstn;
    logic periph_rstn;
    logic cpu_clk_full;
    logic normal_mode;
    logic ddr_pll_pwrdn;
    logic div_rst;
    logic mirror_clk_en;
    logic rate_load;
    logic mirror_rate_load;
    logic force_low;
    logic drive_en;
    logic gpio_oe;
    logic init_done;
    logic mem_test_start;
    logic park_req;
  } cprs_outs_t;

endpackage : cprs_pkg

// ### hdl/cprs_sync.sv
/*
  Two-stage level synchroniser, W bits wide.
  Assumes the source is quiet or slow against clk_in.
*/
`timescale 1ns/1ns
`default_nettype none

module cprs_sync #(
  parameter int W = 2
) (
  input wire logic clk_in,           // reference clock
  input wire logic ce_in,            // clock enable
  input wire logic [W-1:0] d_in,     // asynchronous levels
  output logic [W-1:0] q_out         // synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // no reset: a reset value would fake a falling sense edge
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule : cprs_sync

`default_nettype wire

// ### hdl/cprs_top.sv
/*
  Power-up, system-reset and bring-up sequencer of the display controller.
  Assumes an external monitor drives power-on sense and power-good, and
  that the processor, DDR PLL and memory tester report through inputs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cprs_regs.svh"

module cprs_top #(
  parameter int LOCK_CYC = `CPRS_LOCK_CYC,
  parameter int PG_IGN_CYC = `CPRS_PG_IGN_CYC
) (
  input wire logic clk_in,                    // 50 MHz reference
  input wire logic resetn_in,                 // system reset, active low
  input wire logic ce_in,                     // clock enable
  input wire logic power_on_sense_in,         // monitor: supplies good
  input wire logic power_good_warning_in,     // monitor: low = failing soon
  input wire logic boot_done_in,              // processor finished boot
  input wire logic pll_lock_in,               // mirror DDR PLL locked
  input wire logic mem_test_done_in,          // memory test finished
  input wire logic standby_req_in,            // software asks for standby
  input wire logic wake_cmd_in,               // user wake-up command
  output logic master_pll_rstn_out,           // master PLL reset, low
  output logic core_rstn_out,                 // processor reset, low
  output logic periph_rstn_out,               // other resets, low
  output logic cpu_clk_full_out,              // processor clocks full rate
  output logic normal_mode_out,               // normal power mode
  output logic mirror_ddr_pll_pwrdn_out,      // DDR PLL powered down
  output logic ddr_clock_generator_rst_out,   // divider reset
  output logic mirror_clk_en_out,             // derived mirror clocks run
  output logic rate_load_out,                 // load generator rates
  output logic mirror_rate_load_out,          // load mirror clock rates
  output logic mirror_if_low_out,             // mirror outputs forced low
  output logic mirror_reset_drive_enable_out,    // pin value
  output logic mirror_reset_drive_enable_oe_out, // pin driven
  output logic gpio_oe_out,                   // general pins driven
  output logic init_complete_pin_out,         // init complete value
  output logic init_complete_pin_oe_out,      // init complete driven
  output logic mem_test_start_out,            // run memory test
  output logic park_req_out                   // park mirror array
);
  import cprs_pkg::*;

  localparam int LOCK_W = $clog2(LOCK_CYC) + 1;
  localparam int IGN_W = $clog2(PG_IGN_CYC) + 1;

  // ----------------------------------------------------------------
  // output decode per state
  // ----------------------------------------------------------------
  function automatic cprs_outs_t outs_f(input cprs_state_t s);
    cprs_outs_t o;
    o = '0;
    if (s != ST_OFF) begin
      o.master_pll_rstn = 1'b1;
      o.normal_mode = (s != ST_STANDBY);
      o.cpu_clk_full = (s != ST_STANDBY);
      o.ddr_pll_pwrdn = 1'b1;
      o.div_rst = 1'b1;
      o.force_low = 1'b1;
    end
    unique case (s)
      ST_OFF, ST_SYSRST, ST_LOCK: begin
      end
      ST_BOOT: begin
        o.core_rstn = 1'b1;
      end
      ST_DCGRATE: begin
        o.core_rstn = 1'b1;
        o.periph_rstn = 1'b1;
        o.rate_load = 1'b1;
      end
      ST_PLLEN, ST_MCLK: begin
        o.core_rstn = 1'b1;
        o.periph_rstn = 1'b1;
        o.ddr_pll_pwrdn = 1'b0;
        o.mirror_rate_load = (s == ST_MCLK);
      end
      ST_DIVREL, ST_MEMTEST, ST_DONE, ST_PARK: begin
        o.core_rstn = 1'b1;
        o.periph_rstn = 1'b1;
        o.ddr_pll_pwrdn = 1'b0;
        o.div_rst = 1'b0;
        o.mirror_clk_en = 1'b1;
        o.force_low = 1'b0;
        o.drive_en = (s != ST_DIVREL);
        o.mem_test_start = (s == ST_MEMTEST);
        o.init_done = (s == ST_DONE);
        o.gpio_oe = (s == ST_DONE) || (s == ST_PARK);
        o.park_req = (s == ST_PARK);
      end
      ST_STANDBY: begin
        o.core_rstn = 1'b1;
        o.periph_rstn = 1'b1;
        o.gpio_oe = 1'b1;
        o.init_done = 1'b1;
      end
      default: begin
      end
    endcase
    return o;
  endfunction : outs_f

  localparam cprs_outs_t RST_OUTS = outs_f(ST_SYSRST);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] mon_s;
  logic ps_s;
  logic pg_s;

  cprs_sync #(.W(2)) u_sync (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .d_in({power_on_sense_in, power_good_warning_in}),
    .q_out(mon_s)
  );
  assign ps_s = mon_s[1];
  assign pg_s = mon_s[0];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  cprs_state_t state_r, state_nxt;
  logic ps_d_r, ps_d_nxt;
  logic [LOCK_W-1:0] lock_cnt_r, lock_cnt_nxt;
  logic [IGN_W-1:0] ign_cnt_r, ign_cnt_nxt;
  logic ign_done_r, ign_done_nxt;
  cprs_outs_t outs_r;
  logic ps_rise;
  logic pg_fail;

  assign ps_rise = ps_s & ~ps_d_r;
  // the warning only counts once the ignore window has run out
  assign pg_fail = ~pg_s & ign_done_r;

  always_comb begin
    state_nxt = state_r;
    ps_d_nxt = ps_s;
    lock_cnt_nxt = lock_cnt_r;
    ign_cnt_nxt = ign_cnt_r;
    ign_done_nxt = ign_done_r;
    if (ps_rise) begin
      ign_cnt_nxt = '0;
      ign_done_nxt = 1'b0;
    end else if (!ign_done_r) begin
      if (ign_cnt_r == IGN_W'(PG_IGN_CYC - 1))
        ign_done_nxt = 1'b1;
      else
        ign_cnt_nxt = ign_cnt_r + 1'b1;
    end
    unique case (state_r)
      ST_OFF: begin
        if (ps_rise) begin
          state_nxt = ST_LOCK;
          lock_cnt_nxt = '0;
        end
      end
      ST_SYSRST: state_nxt = ST_BOOT;
      ST_LOCK: begin
        if (lock_cnt_r == LOCK_W'(LOCK_CYC - 1))
          state_nxt = ST_BOOT;
        else
          lock_cnt_nxt = lock_cnt_r + 1'b1;
      end
      ST_BOOT: if (boot_done_in) state_nxt = ST_DCGRATE;
      ST_DCGRATE: state_nxt = ST_PLLEN;
      ST_PLLEN: if (pll_lock_in) state_nxt = ST_MCLK;
      ST_MCLK: state_nxt = ST_DIVREL;
      ST_DIVREL: state_nxt = ST_MEMTEST;
      ST_MEMTEST: if (mem_test_done_in) state_nxt = ST_DONE;
      ST_DONE: if (standby_req_in) state_nxt = ST_STANDBY;
      ST_STANDBY: if (wake_cmd_in) state_nxt = ST_DCGRATE;
      ST_PARK: if (pg_s) state_nxt = ST_SYSRST;
      default: state_nxt = ST_SYSRST;
    endcase
    if (pg_fail && state_r != ST_OFF && state_r != ST_LOCK &&
        state_r != ST_SYSRST)
      state_nxt = ST_PARK;
    if (!ps_s)
      state_nxt = ST_OFF;
  end

  // system reset leaves the master PLL alone; only sense low resets it
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      // sense low during reset still means power off: keep pins quiet
      state_r <= ps_s ? ST_SYSRST : ST_OFF;
      ps_d_r <= 1'b1;
      lock_cnt_r <= '0;
      ign_cnt_r <= '0;
      ign_done_r <= 1'b1;
      outs_r <= ps_s ? RST_OUTS : cprs_outs_t'('0);
    end else if (ce_in) begin
      state_r <= state_nxt;
      ps_d_r <= ps_d_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      ign_cnt_r <= ign_cnt_nxt;
      ign_done_r <= ign_done_nxt;
      outs_r <= outs_f(state_nxt);
    end
  end

  assign master_pll_rstn_out = outs_r.master_pll_rstn;
  assign core_rstn_out = outs_r.core_rstn;
  assign periph_rstn_out = outs_r.periph_rstn;
  assign cpu_clk_full_out = outs_r.cpu_clk_full;
  assign normal_mode_out = outs_r.normal_mode;
  assign mirror_ddr_pll_pwrdn_out = outs_r.ddr_pll_pwrdn;
  assign ddr_clock_generator_rst_out = outs_r.div_rst;
  assign mirror_clk_en_out = outs_r.mirror_clk_en;
  assign rate_load_out = outs_r.rate_load;
  assign mirror_rate_load_out = outs_r.mirror_rate_load;
  assign mirror_if_low_out = outs_r.force_low;
  assign mirror_reset_drive_enable_out = outs_r.drive_en;
  assign mirror_reset_drive_enable_oe_out = outs_r.drive_en;
  assign gpio_oe_out = outs_r.gpio_oe;
  assign init_complete_pin_out = outs_r.init_done;
  assign init_complete_pin_oe_out = outs_r.gpio_oe;
  assign mem_test_start_out = outs_r.mem_test_start;
  assign park_req_out = outs_r.park_req;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // sense loss or a live warning legally pre-empts the pll step
  sequence cfg_start_s;
    rate_load_out && ce_in && ps_s && !pg_fail;
  endsequence
  sequence pll_enabled_s;
    !mirror_ddr_pll_pwrdn_out && ddr_clock_generator_rst_out &&
      !rate_load_out;
  endsequence

  sense_low_quiet_a: assert property ((state_r == ST_OFF) |->
    !master_pll_rstn_out && !core_rstn_out && !gpio_oe_out &&
    !mirror_reset_drive_enable_oe_out && !init_complete_pin_oe_out)
    else $error("output active while sense low");
  pll_release_a: assert property ((ce_in && ps_rise && state_r == ST_OFF)
    |=> master_pll_rstn_out && !core_rstn_out)
    else $error("master pll not released on sense rise");
  lock_hold_a: assert property ((state_r == ST_LOCK && ce_in &&
    lock_cnt_r != LOCK_W'(LOCK_CYC - 1) && ps_s) |=> !core_rstn_out)
    else $error("core released before lock delay");
  pg_ignore_a: assert property ($rose(state_r == ST_PARK) |->
    $past(ign_done_r))
    else $error("warning acted on inside ignore window");
  park_entry_a: assert property ((ce_in && pg_fail && ps_s &&
    state_r inside {ST_BOOT, ST_DONE, ST_MEMTEST}) |=> park_req_out)
    else $error("no park on power-good warning");
  ddr_off_a: assert property ((state_r == ST_BOOT) |->
    mirror_ddr_pll_pwrdn_out && ddr_clock_generator_rst_out &&
    !mirror_clk_en_out && cpu_clk_full_out && !gpio_oe_out)
    else $error("boot defaults wrong");
  mirror_low_a: assert property ((state_r == ST_BOOT) |->
    mirror_if_low_out && !mirror_reset_drive_enable_oe_out)
    else $error("mirror pins not low at boot");
  reset_hold_a: assert property ((state_r inside {ST_LOCK, ST_BOOT,
    ST_SYSRST}) |-> !periph_rstn_out)
    else $error("resets released before boot");
  cfg_order_a: assert property (cfg_start_s |=> pll_enabled_s)
    else $error("pll not enabled after rate load");
  init_flag_a: assert property ((ce_in && ps_s && pg_s &&
    state_r == ST_MEMTEST && mem_test_done_in) |=>
    init_complete_pin_out && init_complete_pin_oe_out)
    else $error("init complete not raised");

endmodule : cprs_top

`default_nettype wire

// ### tb/cprs_power_monitor.sv
/*
  Behavioural model of the external power monitor and supply sequencer.
  Assumes the bench commands supply ramp, brownout and power removal.
*/
`timescale 1ns/1ns
`default_nettype none

module cprs_power_monitor #(
  parameter int RAMP_CYC = 4,
  parameter int WARN_LEAD_CYC = 25
) (
  input wire logic clk_in,             // reference clock
  input wire logic supply_on_in,       // supplies switched on
  input wire logic brownout_in,        // input side sagging
  output logic power_on_sense_out,     // all supplies good
  output logic power_good_warning_out  // low = supplies fail soon
);
  int cnt;

  initial begin
    cnt = 0;
    power_on_sense_out = 1'b0;
    power_good_warning_out = 1'b0;
  end

  // warn lead is the scaled stand-in for the real half millisecond
  always @(posedge clk_in) begin
    if (supply_on_in && !power_on_sense_out) begin
      cnt <= cnt + 1;
      if (cnt == RAMP_CYC) begin
        power_on_sense_out <= 1'b1;
        power_good_warning_out <= 1'b1;
        cnt <= 0;
      end
    end else if (!supply_on_in && power_on_sense_out) begin
      power_good_warning_out <= 1'b0;
      cnt <= cnt + 1;
      if (cnt == WARN_LEAD_CYC) begin
        power_on_sense_out <= 1'b0;
        cnt <= 0;
      end
    end else begin
      power_good_warning_out <= power_on_sense_out && !brownout_in;
    end
  end
endmodule : cprs_power_monitor

`default_nettype wire

// ### tb/cprs_top_tb_top.sv
/*
  Self-checking bench of cprs_top driven through the power monitor model.
  Assumes shortened lock and ignore counts handed in as parameters.
*/
`timescale 1ns/1ns
`default_nettype none

module cprs_top_tb_top;
  localparam int LOCK = 20;
  localparam logic [17:0] ALL = 18'h3FFFF;
  localparam logic [17:0] SYSR = 18'h27880;
  localparam logic [17:0] BOOT = 18'h37880;
  localparam logic [17:0] RATE = 18'h3FA80;
  localparam logic [17:0] PLLEN = 18'h3E880;
  localparam logic [17:0] MCLK = 18'h3E980;
  localparam logic [17:0] DIVREL = 18'h3E400;
  localparam logic [17:0] MEMT = 18'h3E462;
  localparam logic [17:0] DONE = 18'h3E47C;
  localparam logic [17:0] PARK = 18'h20001;

  logic clk_in, resetn_in, ce_in, boot_done_in, pll_lock_in;
  logic mem_test_done_in, standby_req_in, wake_cmd_in, supply_on, brownout;
  logic power_on_sense_in, power_good_warning_in;
  logic master_pll_rstn_out, core_rstn_out, periph_rstn_out;
  logic cpu_clk_full_out, normal_mode_out, mirror_ddr_pll_pwrdn_out;
  logic ddr_clock_generator_rst_out, mirror_clk_en_out, rate_load_out;
  logic mirror_rate_load_out, mirror_if_low_out, gpio_oe_out;
  logic mirror_reset_drive_enable_out, mirror_reset_drive_enable_oe_out;
  logic init_complete_pin_out, init_complete_pin_oe_out;
  logic mem_test_start_out, park_req_out;
  logic [17:0] obs;
  logic [35:0] nt;
  logic [35:0] q_exp[$];
  int bad_count = 0;
  int tests_run = 0;
  integer seed = 32'hdf20565b;

  assign obs = {master_pll_rstn_out, core_rstn_out, periph_rstn_out,
    cpu_clk_full_out, normal_mode_out, mirror_ddr_pll_pwrdn_out,
    ddr_clock_generator_rst_out, mirror_clk_en_out, rate_load_out,
    mirror_rate_load_out, mirror_if_low_out, mirror_reset_drive_enable_out,
    mirror_reset_drive_enable_oe_out, gpio_oe_out, init_complete_pin_out,
    init_complete_pin_oe_out, mem_test_start_out, park_req_out};

  cprs_power_monitor u_cprs_power_monitor (
    .clk_in, .supply_on_in(supply_on), .brownout_in(brownout),
    .power_on_sense_out(power_on_sense_in),
    .power_good_warning_out(power_good_warning_in)
  );

  cprs_top #(.LOCK_CYC(LOCK), .PG_IGN_CYC(10)) u_cprs_top (
    .clk_in, .resetn_in, .ce_in, .power_on_sense_in, .power_good_warning_in,
    .boot_done_in, .pll_lock_in, .mem_test_done_in, .standby_req_in,
    .wake_cmd_in, .master_pll_rstn_out, .core_rstn_out, .periph_rstn_out,
    .cpu_clk_full_out, .normal_mode_out, .mirror_ddr_pll_pwrdn_out,
    .ddr_clock_generator_rst_out, .mirror_clk_en_out, .rate_load_out,
    .mirror_rate_load_out, .mirror_if_low_out,
    .mirror_reset_drive_enable_out, .mirror_reset_drive_enable_oe_out,
    .gpio_oe_out, .init_complete_pin_out, .init_complete_pin_oe_out,
    .mem_test_start_out, .park_req_out
  );

  // ----------------------------------------
  // clock, tasks and scoreboard
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic note(input logic [17:0] e, input logic [17:0] m);
    q_exp.push_back({e, m});
  endtask : note

  task automatic check_out(input logic [17:0] e, input logic [17:0] m);
    tests_run++;
    if ((obs & m) !== e) begin
      bad_count++;
      $display("ERROR outputs expected %h seen %h", e, obs & m);
    end
  endtask : check_out

  always @(negedge clk_in) begin
    while (q_exp.size() > 0) begin
      nt = q_exp.pop_front();
      check_out(nt[35:18], nt[17:0]);
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // random waits show that nothing moves before its input arrives
  task automatic clocks();
    pll_lock_in = 1'b1;
    tick(1);
    pll_lock_in = 1'b0;
    note(MCLK, ALL);
    tick(1);
    note(DIVREL, ALL);
    tick(1 + ($random(seed) & 7));
    note(MEMT, ALL);
    mem_test_done_in = 1'b1;
    tick(1);
    mem_test_done_in = 1'b0;
    note(DONE, ALL);
  endtask : clocks

  task automatic bring_up();
    tick(1 + ($random(seed) & 7));
    note(BOOT, ALL);
    boot_done_in = 1'b1;
    tick(1);
    boot_done_in = 1'b0;
    note(RATE, ALL);
    tick(1 + ($random(seed) & 7));
    note(PLLEN, ALL);
    clocks();
  endtask : bring_up

  initial begin
    #(20 * 5000);
    bad_count++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn_in, boot_done_in, pll_lock_in, mem_test_done_in} = '0;
    {standby_req_in, wake_cmd_in, supply_on, brownout} = '0;
    ce_in = 1'b1;
    tick(16);
    resetn_in = 1'b1;
    tick(1);
    note('0, ALL);
    supply_on = 1'b1;
    @(posedge power_on_sense_in);
    tick(2);
    note('0, ALL);
    tick(1);
    note(SYSR, ALL);
    tick(LOCK - 1);
    note(SYSR, ALL);
    tick(1);
    note(BOOT, ALL);
    bring_up();
    standby_req_in = 1'b1;
    tick(1);
    standby_req_in = 1'b0;
    note(18'h01000, 18'h07000);
    tick(3);
    note(18'h01000, 18'h07000);
    ce_in = 1'b0;
    wake_cmd_in = 1'b1;
    tick(1 + ($random(seed) & 3));
    note(18'h01000, 18'h07000);
    ce_in = 1'b1;
    tick(1);
    wake_cmd_in = 1'b0;
    note(18'h02200, 18'h02200);
    tick(1);
    clocks();
    brownout = 1'b1;
    @(negedge power_good_warning_in);
    tick(2);
    note('0, 18'h00001);
    tick(1);
    note(PARK, PARK);
    brownout = 1'b0;
    @(posedge power_good_warning_in);
    tick(3);
    note(SYSR, ALL);
    tick(1);
    note(BOOT, ALL);
    resetn_in = 1'b0;
    tick(3);
    note(SYSR, ALL);
    resetn_in = 1'b1;
    tick(1);
    note(BOOT, ALL);
    bring_up();
    supply_on = 1'b0;
    @(negedge power_good_warning_in);
    tick(3);
    note(PARK, PARK);
    @(negedge power_on_sense_in);
    tick(3);
    note('0, ALL);
    tick(1);
    conclude();
  end
endmodule : cprs_top_tb_top

`default_nettype wire
